// ### fctg_asserts.sv
// Checker bound to fctg_top: link hold, ordered sets, error gating, receive math.
// Assumes inputs change away from the rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module fctg_asserts #(
	parameter int SEC_CYCLES = 50 // Clocks per second
) (
	input wire logic CLK, // Clock
	input wire logic RST, // Reset
	input wire logic TEN_GIG_RATE_MODE, // Mode
	input wire logic signed [31:0] FREQ_DEV, // Asked
	input wire logic TX_READY, // Sink ready
	input wire fctg_pkg::fctg_rxst_t RX_ST_PIN, // Raw status
	input wire logic RX_WIN_STB, // Window
	input wire logic [31:0] RX_BIT_CNT, // Bits
	input wire logic [31:0] NOM_BITS, // Nominal
	input wire logic [31:0] WIN_PER_SEC, // Scale
	input wire logic MEAS_START, // Restart
	input wire fctg_pkg::fctg_word_t TX_WORD, // Word
	input wire logic TX_VALID, // Valid
	input wire logic ENC_64B66B, // Coding
	input wire logic signed [31:0] TX_DEV, // Applied
	input wire logic signed [31:0] RX_DEV_BPS, // Rate diff
	input wire logic signed [47:0] RX_ACC_DIFF, // Sum
	input wire fctg_pkg::fctg_rxst_t RX_ST // Status
);
	import fctg_pkg::*;
	// One domain, so one clock and one reset serve every check
	default clocking dck @(posedge CLK);
	endclocking
	default disable iff (RST);
	hold_stall_a: assert property (
		TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_WORD))
		else $error("word changed while stalled");
	comma_first_a: assert property (
		TX_VALID && TX_WORD.k != 4'h0 |-> TX_WORD.k == 4'h8 && TX_WORD.data[31:24] == 8'hBC)
		else $error("control word without leading comma");
	sym_gate_a: assert property (
		TX_VALID && TX_WORD.inv |-> !ENC_64B66B)
		else $error("symbol error in block coding");
	blk_gate_a: assert property (
		TX_VALID && TX_WORD.blk |-> ENC_64B66B)
		else $error("block error in byte coding");
	enc_follow_a: assert property (
		$changed(TEN_GIG_RATE_MODE) |=> ENC_64B66B == $past(TEN_GIG_RATE_MODE))
		else $error("coding select lags mode");
	dev_follow_a: assert property (
		$changed(FREQ_DEV) |=> TX_DEV == $past(FREQ_DEV))
		else $error("deviation not applied");
	acc_clear_a: assert property (
		MEAS_START |=> RX_ACC_DIFF == 48'h000000000000)
		else $error("accumulator not cleared");
	acc_step_a: assert property (
		RX_WIN_STB && !MEAS_START |=> RX_ACC_DIFF == $past(RX_ACC_DIFF)
			+ $past({16'h0000, RX_BIT_CNT}) - $past({16'h0000, NOM_BITS}))
		else $error("accumulator step wrong");
	bps_calc_a: assert property (
		RX_WIN_STB |=> RX_DEV_BPS == $past(RX_BIT_CNT - NOM_BITS) * $past(WIN_PER_SEC))
		else $error("rate difference wrong");
	status_sync_a: assert property (
		$stable(RX_ST_PIN) [*4] |-> RX_ST == RX_ST_PIN)
		else $error("status not passed through");
	cover property (TX_VALID && TX_READY && TX_WORD.data == OS_LR);
	cover property (TX_VALID && !TX_READY);
	cover property (TX_VALID && TX_WORD.blk);
endmodule // fctg_asserts
bind fctg_top fctg_asserts #(.SEC_CYCLES(SEC_CYCLES)) chk (.CLK(CLK), .RST(RST),
	.TEN_GIG_RATE_MODE(TEN_GIG_RATE_MODE), .FREQ_DEV(FREQ_DEV), .TX_READY(TX_READY),
	.RX_ST_PIN(RX_ST_PIN), .RX_WIN_STB(RX_WIN_STB), .RX_BIT_CNT(RX_BIT_CNT),
	.NOM_BITS(NOM_BITS), .WIN_PER_SEC(WIN_PER_SEC), .MEAS_START(MEAS_START),
	.TX_WORD(TX_WORD), .TX_VALID(TX_VALID), .ENC_64B66B(ENC_64B66B), .TX_DEV(TX_DEV),
	.RX_DEV_BPS(RX_DEV_BPS), .RX_ACC_DIFF(RX_ACC_DIFF), .RX_ST(RX_ST));
`default_nettype wire

// ### fctg_pkg.sv
// Constants, types and encodings for the test frame generator and injector.
// Assumes a downstream line encoder that maps k/inv/blk flags onto code groups.
`default_nettype none
package fctg_pkg;
	localparam int CLK_HZ = 250_000_000;
	localparam int PERIOD_S = 1; // Periodic insertion base, seconds
	localparam int SEC_CYC = PERIOD_S * CLK_HZ;
	localparam logic [3:0] TEN_PERIODS = 4'hA;
	localparam logic [3:0] GAP_WORDS = 4'h6; // Gap reload; seven idle words go between frames
	localparam logic [9:0] HDR_WORDS = 10'h006;
	localparam logic [7:0] K285 = 8'hBC;
	// Ordered sets, comma first
	localparam logic [31:0] OS_LR = {K285, 8'h49, 8'hBF, 8'h49};
	localparam logic [31:0] OS_LRR = {K285, 8'h35, 8'hBF, 8'h49};
	localparam logic [31:0] OS_NOS = {K285, 8'h55, 8'hBF, 8'h45};
	localparam logic [31:0] OS_OLS = {K285, 8'h35, 8'h8A, 8'h55};
	localparam logic [31:0] OS_RRDY = {K285, 8'h95, 8'h4A, 8'h4A};
	localparam logic [31:0] OS_IDLE = {K285, 8'h95, 8'hB5, 8'hB5};
	localparam logic [31:0] OS_SOF = {K285, 8'hB5, 8'h56, 8'h56};
	localparam logic [31:0] OS_EOF = {K285, 8'h95, 8'hD5, 8'hD5};
	localparam logic [3:0] K_OS = 4'h8;
	// Fixed header fields
	localparam logic [7:0] HDR_RCTL = 8'h00;
	localparam logic [7:0] HDR_CSCTL = 8'h00;
	localparam logic [7:0] HDR_TYPE = 8'hE0;
	localparam logic [23:0] HDR_FCTL = 24'h000000;
	localparam logic [7:0] HDR_DFCTL = 8'h00;
	localparam logic [31:0] HDR_PARM = 32'h00000000;
	localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
	localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
	localparam logic [31:0] PAT_5555 = 32'h55555555;
	localparam int FOX_LEN = 55;
	localparam logic [439:0] FOX_TXT = "The quick brown fox jumped over the lazy dog 1234567890";
	localparam logic [15:0] PEND_MAX = 16'hFFFF;
	typedef enum logic [2:0] {ALM_NONE, ALM_LR, ALM_LRR, ALM_NOS, ALM_OLS} fctg_alm_t;
	typedef enum logic [2:0] {ERR_NONE, ERR_BIT, ERR_SYM, ERR_RRDY, ERR_CRC, ERR_BLK} fctg_err_t;
	typedef enum logic [3:0] {INS_OFF, INS_MAN, INS_SEC, INS_10SEC, INS_R2, INS_R3, INS_R4,
		INS_R5, INS_R6, INS_R7} fctg_ins_t;
	typedef enum logic [2:0] {PAT_FOX, PAT_55, PAT_PRBS, PAT_USER, PAT_ZERO} fctg_pat_t;
	typedef struct packed {
		logic [31:0] data;
		logic [3:0] k; // Control-character flag per byte
		logic inv; // Force invalid 10-bit code group
		logic blk; // Corrupt this 64b/66b block
	} fctg_word_t;
	typedef struct packed {
		logic [23:0] d_id;
		logic [23:0] s_id;
		logic [7:0] seq_id;
		logic [15:0] ox_id;
		logic [15:0] rx_id;
	} fctg_hdr_t;
	typedef struct packed {
		logic sig_det;
		logic word_sync;
		logic traffic;
		logic pat_sync;
		logic pat_err;
	} fctg_rxst_t;
endpackage
`default_nettype wire

// ### fctg_sink.sv
// Far-side model: encoder and port under test taking transmit words.
// Assumes one clock; the bench reads accepted words from q in order.
`timescale 1ns/100ps
`default_nettype none
module fctg_sink (
	input wire logic clk, // Clock
	input wire logic rst, // Reset, active high
	input wire fctg_pkg::fctg_word_t word, // Offered word
	input wire logic valid, // Word offered
	input wire logic stall, // Slow mode
	output logic ready // Takes word
);
	import fctg_pkg::*;
	logic [1:0] ph_r;
	fctg_word_t q[$];
	// Slow mode takes one word in four, so the generator must hold its head
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ph_r <= 2'h0;
			ready <= 1'b0;
		end else begin
			ph_r <= ph_r + 2'h1;
			ready <= !stall || ph_r == 2'h3;
		end
	end
	// Record each word at the edge that takes it
	always @(posedge clk)
		if (!rst && valid && ready)
			q.push_back(word);
endmodule // fctg_sink
`default_nettype wire

// ### fctg_tb_top.sv
// Bench for fctg_top: payloads, framing, alarms, error insertion, receive side.
// Assumes fctg_sink as far side and fctg_asserts bound to the top.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module fctg_tb_top;
	import fctg_pkg::*;
	logic clk = 1'b0, rst = 1'b1, tx_en = 1'b0, framed = 1'b0, ten_g = 1'b0, stall = 1'b0;
	logic trig = 1'b0, stb = 1'b0, meas = 1'b0, tx_ready, tx_valid, enc;
	logic [9:0] pay_words = 10'h002;
	logic [15:0] burst = 16'h0000;
	logic [31:0] user_word = 32'hA5A50F0F, bit_cnt = 32'h0, nom = 32'h3E8, wps = 32'hA;
	logic signed [31:0] freq_dev = 32'h0, tx_dev, bps, ppm;
	logic signed [47:0] acc;
	fctg_pat_t pat_sel = PAT_FOX;
	fctg_hdr_t hdr = {24'h123456, 24'hABCDEF, 8'h5A, 16'h1234, 16'h9876};
	fctg_alm_t alm_sel = ALM_NONE;
	fctg_err_t err_sel = ERR_NONE;
	fctg_ins_t ins_sel = INS_OFF;
	fctg_rxst_t st_pin = 5'h00, st;
	fctg_word_t tx_word, w[$];
	fctg_pat_t pt [3] = '{PAT_55, PAT_USER, PAT_ZERO};
	logic [31:0] pv [3] = '{32'h55555555, 32'hA5A50F0F, 32'h00000000};
	logic [31:0] c, eh [7];
	int checked = 0, miscompares = 0, cyc = 0, s;
	fctg_top #(.SEC_CYCLES(50)) uut (.CLK(clk), .RST(rst), .TX_EN(tx_en), .FRAMED(framed),
		.TEN_GIG_RATE_MODE(ten_g), .PAY_WORDS(pay_words), .PAT_SEL(pat_sel), .PRBS_ORDER(5'h09),
		.USER_WORD(user_word), .HDR(hdr), .ALM_SEL(alm_sel), .ERR_SEL(err_sel), .INS_SEL(ins_sel),
		.BURST_LEN(burst), .INS_TRIG(trig), .FREQ_DEV(freq_dev), .TX_READY(tx_ready),
		.RX_ST_PIN(st_pin), .RX_WIN_STB(stb), .RX_BIT_CNT(bit_cnt), .NOM_BITS(nom),
		.WIN_PER_SEC(wps), .PPM_GAIN(32'h00030000), .MEAS_START(meas), .TX_WORD(tx_word),
		.TX_VALID(tx_valid), .ENC_64B66B(enc), .TX_DEV(tx_dev), .RX_DEV_BPS(bps),
		.RX_DEV_PPM(ppm), .RX_ACC_DIFF(acc), .RX_ST(st));
	fctg_sink sink (.clk(clk), .rst(rst), .word(tx_word), .valid(tx_valid), .stall(stall),
		.ready(tx_ready));
	// 250 MHz clock
	always #2 clk = ~clk;
	// Hang guard, well above the few thousand cycles the tests need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			miscompares++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Data byte Dx.y, or K28.5 when called with 28 and 5
	function automatic logic [7:0] dc(input int x, input int y);
		return 8'(y * 32 + x);
	endfunction
	function automatic logic [31:0] os(input int a, b, c, d, e, f);
		return {dc(28, 5), dc(a, b), dc(c, d), dc(e, f)};
	endfunction
	// Serial CRC, most significant bit first
	function automatic logic [31:0] crc_w(input logic [31:0] r, input logic [31:0] d);
		for (int b = 31; b >= 0; b--)
			r = (r[31] ^ d[b]) ? {r[30:0], 1'b0} ^ CRC_POLY : {r[30:0], 1'b0};
		return r;
	endfunction
	function automatic int sof_at();
		for (int i = 0; i < w.size(); i++)
			if (w[i].k === 4'h8 && w[i].data === OS_SOF) return i;
		return 0;
	endfunction
	// Counts ordered sets, one-bit payload or CRC flips, or error flags in the capture
	function automatic int cnt(input fctg_err_t e, input logic [31:0] v);
		int n = 0;
		logic [31:0] r;
		foreach (w[i])
			case (e)
				ERR_NONE: n += (w[i].k === 4'h8 && w[i].data === v);
				ERR_BIT: n += (w[i].k === 4'h0 && $countones(w[i].data ^ v) == 1);
				ERR_SYM: n += (w[i].inv === 1'b1);
				ERR_CRC: if (w[i].data === OS_SOF && i + 11 < w.size()) begin
					r = CRC_INIT;
					for (int j = 1; j < 11; j++)
						r = crc_w(r, w[i + j].data);
					n += ($countones(r ^ ~w[i + 11].data) == 1);
				end
				default: n += (w[i].blk === 1'b1);
			endcase
		return n;
	endfunction
	task automatic grab(input int n, input bit keep = 1'b0);
		if (!keep) @(negedge clk) sink.q.delete();
		wait (sink.q.size() >= n);
		w = sink.q;
	endtask
	// Mode settles first so no flagged word meets a coding change
	task automatic run_err(input fctg_err_t e, input logic g, input fctg_ins_t m,
		input int b, input int nw, input int lo, input int hi);
		int n;
		@(negedge clk) ten_g = g;
		repeat (4) @(negedge clk);
		err_sel = e;
		ins_sel = m;
		burst = 16'(b);
		@(negedge clk) trig = (m == INS_MAN || m == INS_OFF);
		@(negedge clk) trig = 1'b0;
		grab(nw);
		n = cnt(e == ERR_RRDY ? ERR_NONE : e, e == ERR_RRDY ? os(21, 4, 10, 2, 10, 2) : user_word);
		`CHK("error count in range", 1'b1, (n >= lo && n <= hi))
		@(negedge clk) err_sel = ERR_NONE;
		ins_sel = INS_OFF;
		repeat (4) @(negedge clk);
	endtask
	initial begin
		repeat (10) @(negedge clk);
		`CHK("valid in reset", 1'b0, tx_valid)
		rst = 1'b0;
		tx_en = 1'b1;
		@(negedge clk);
		`CHK("valid after one edge", 1'b1, tx_valid)
		@(negedge clk);
		`CHK("valid after two edges", 1'b1, tx_valid)
		grab(20, 1'b1);
		s = sof_at();
		`CHK("gap before frame", 1'b1, (s >= 6))
		`CHK("fox word 0", 32'h54686520, w[s + 1].data)
		`CHK("fox word 1", 32'h71756963, w[s + 2].data)
		`CHK("unframed end", os(21, 4, 21, 6, 21, 6), w[s + 3].data)
		// Order 9 obeys x^9 + x^5 + 1 inside one word, and is never all zero
		@(negedge clk) pat_sel = PAT_PRBS;
		grab(30);
		c = w[sof_at() + 1].data;
		`CHK("prbs9 recurrence", {1'b1, c[31:9] ^ c[27:5]}, {|c, c[22:0]})
		for (int p = 0; p < 3; p++) begin
			@(negedge clk) pat_sel = pt[p];
			repeat (20) @(negedge clk);
			grab(30);
			`CHK("payload word", pv[p], w[sof_at() + 1].data)
		end
		// Framed, one zero payload word, far side stalling
		@(negedge clk) framed = 1'b1;
		pay_words = 10'h001;
		stall = 1'b1;
		repeat (40) @(negedge clk);
		grab(60);
		s = sof_at();
		eh = '{{HDR_RCTL, hdr.d_id}, {HDR_CSCTL, hdr.s_id}, {HDR_TYPE, HDR_FCTL},
			{hdr.seq_id, HDR_DFCTL, w[s + 4].data[15:0]}, {hdr.ox_id, hdr.rx_id}, HDR_PARM, 32'h0};
		c = CRC_INIT;
		for (int i = 0; i < 7; i++) begin
			`CHK("framed word", eh[i], w[s + 1 + i].data)
			c = crc_w(c, eh[i]);
		end
		`CHK("crc word", ~c, w[s + 8].data)
		`CHK("framed end", os(21, 4, 21, 6, 21, 6), w[s + 9].data)
		`CHK("seq step", w[s + 4].data[15:0] + 16'h1, w[s + 15 + GAP_WORDS].data[15:0])
		@(negedge clk) framed = 1'b0;
		stall = 1'b0;
		pat_sel = PAT_USER;
		pay_words = 10'h004;
		// Each alarm replaces all traffic with its ordered set
		eh = '{os(9, 2, 31, 5, 9, 2), os(21, 1, 31, 5, 9, 2), os(21, 2, 31, 5, 5, 2),
			os(21, 1, 10, 4, 21, 2), 32'h0, 32'h0, 32'h0};
		for (int a = 0; a < 4; a++) begin
			@(negedge clk) alm_sel = fctg_alm_t'(a + 1);
			repeat (30) @(negedge clk);
			grab(20);
			`CHK("alarm words", 20, cnt(ERR_NONE, eh[a]))
		end
		@(negedge clk) alm_sel = ALM_NONE;
		repeat (30) @(negedge clk);
		run_err(ERR_RRDY, 1'b0, INS_MAN, 3, 300, 3, 3);
		run_err(ERR_RRDY, 1'b0, INS_OFF, 3, 300, 0, 0);
		run_err(ERR_BIT, 1'b0, INS_MAN, 2, 300, 2, 2);
		run_err(ERR_SYM, 1'b0, INS_MAN, 2, 300, 2, 2);
		run_err(ERR_SYM, 1'b1, INS_MAN, 2, 300, 0, 0);
		run_err(ERR_BLK, 1'b1, INS_MAN, 2, 300, 2, 2);
		run_err(ERR_BLK, 1'b0, INS_MAN, 2, 300, 0, 0);
		run_err(ERR_RRDY, 1'b0, INS_SEC, 1, 1000, 19, 21);
		run_err(ERR_RRDY, 1'b0, INS_10SEC, 1, 1000, 1, 3);
		run_err(ERR_RRDY, 1'b0, INS_R2, 1, 1000, 9, 11);
		// First flipped CRC may belong to a frame whose start precedes the capture
		@(negedge clk) framed = 1'b1;
		repeat (30) @(negedge clk);
		run_err(ERR_CRC, 1'b0, INS_MAN, 3, 300, 2, 3);
		// Receive windows: five fast, two slow, then restart with a window
		@(negedge clk) bit_cnt = 32'h3ED;
		stb = 1'b1;
		@(negedge clk) stb = 1'b0;
		@(negedge clk);
		`CHK("bps fast", 32'h00000032, bps)
		`CHK("ppm fast", 32'h0000000F, ppm)
		`CHK("acc fast", 48'h000000000005, acc)
		@(negedge clk) bit_cnt = 32'h3E6;
		stb = 1'b1;
		@(negedge clk) stb = 1'b0;
		@(negedge clk);
		`CHK("bps slow", 32'hFFFFFFEC, bps)
		`CHK("ppm slow", 32'hFFFFFFFA, ppm)
		`CHK("acc slow", 48'h000000000003, acc)
		@(negedge clk) meas = 1'b1;
		stb = 1'b1;
		@(negedge clk) meas = 1'b0;
		stb = 1'b0;
		@(negedge clk);
		`CHK("acc restart", 48'h000000000000, acc)
		for (int v = 0; v < 2; v++) begin
			@(negedge clk) st_pin = v ? 5'h0A : 5'h15;
			repeat (4) @(negedge clk);
			`CHK("status", st_pin, st)
		end
		@(negedge clk) freq_dev = -32'sd7;
		repeat (2) @(negedge clk);
		`CHK("tx deviation", 32'hFFFFFFF9, tx_dev)
		close_out();
	end
endmodule // fctg_tb_top
`default_nettype wire

// ### fctg_top.sv
// Frame generator, error/alarm injector and receive status block.
// Assumes a downstream encoder (8b/10b or 64b/66b) and a receive counter
// delivering bits per window on RX_WIN_STB in this clock domain.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Unframed: SOF, payload, EOF; no header or CRC.
// - Framed: SOF, header, payload, CRC, EOF in order.
// - Pangram payload repeats the ASCII fox sentence ending 1234567890.
// - PRBS orders 9 to 31, maximal length, period two to order minus one.
// - User payload repeats a 32-bit word; zero payload sends zeros.
// - Header is six words in the standard field order.
// - Destination and source IDs, sequence ID, originator and responder exchange IDs are programmable.
// - Selected alarm sends its primitive sequence continuously instead of traffic.
// - Link reset: K28.5 D9.2 D31.5 D9.2.
// - Link reset response: K28.5 D21.1 D31.5 D9.2.
// - Not operational: K28.5 D21.2 D31.5 D5.2.
// - Offline: K28.5 D21.1 D10.4 D21.2.
// - Receiver-ready error inserts K28.5 D21.4 D10.2 D10.2 once per error.
// - Bit error inverts one payload bit per error.
// - Symbol error forces an invalid code group; not in 64b/66b mode.
// - CRC error inverts a CRC bit; not without CRC.
// - Block error corrupts one 64b/66b block; only in 64b/66b mode.
// - Manual inserts burst count per trigger; off inserts none.
// - Periodic modes insert burst every one or ten seconds.
// - Rate modes insert a burst every 1E2 to 1E7 blocks.
// - Transmit frequency offset by signed deviation; positive is faster.
// - Report received rate deviation in ppm and bits per second.
// - Accumulate bit difference; clear on measurement start or restart.
// - Flag bit sync present and word sync separately.
// - Indicate traffic, pattern sync and pattern errors.
// - 8b/10b up to eight gigabit, 64b/66b in ten-gig rate mode.
module fctg_top #(
	parameter int SEC_CYCLES = fctg_pkg::SEC_CYC // Clocks per second
) (
	input wire logic CLK, // 250 MHz clock
	input wire logic RST, // Async reset, active high
	input wire logic TX_EN, // Start frames
	input wire logic FRAMED, // 1: header and CRC present
	input wire logic TEN_GIG_RATE_MODE, // 64b/66b rate mode
	input wire logic [9:0] PAY_WORDS, // Payload words, 0..528
	input wire fctg_pkg::fctg_pat_t PAT_SEL, // Payload pattern
	input wire logic [4:0] PRBS_ORDER, // 9..31
	input wire logic [31:0] USER_WORD, // User pattern
	input wire fctg_pkg::fctg_hdr_t HDR, // Header settings
	input wire fctg_pkg::fctg_alm_t ALM_SEL, // Alarm type
	input wire fctg_pkg::fctg_err_t ERR_SEL, // Error type
	input wire fctg_pkg::fctg_ins_t INS_SEL, // Insertion mode
	input wire logic [15:0] BURST_LEN, // Errors per burst
	input wire logic INS_TRIG, // Manual insert pulse
	input wire logic signed [31:0] FREQ_DEV, // Tx deviation request
	input wire logic TX_READY, // Encoder accepts word
	input wire fctg_pkg::fctg_rxst_t RX_ST_PIN, // Async receive status
	input wire logic RX_WIN_STB, // Rate window done
	input wire logic [31:0] RX_BIT_CNT, // Bits in last window
	input wire logic [31:0] NOM_BITS, // Nominal bits per window
	input wire logic [31:0] WIN_PER_SEC, // Windows per second
	input wire logic [31:0] PPM_GAIN, // ppm per bit, Q16
	input wire logic MEAS_START, // Measurement (re)start
	output fctg_pkg::fctg_word_t TX_WORD, // Word to encoder
	output logic TX_VALID, // Word valid
	output logic ENC_64B66B, // Encoder select
	output logic signed [31:0] TX_DEV, // Applied deviation
	output logic signed [31:0] RX_DEV_BPS, // Rate deviation, bps
	output logic signed [31:0] RX_DEV_PPM, // Rate deviation, ppm
	output logic signed [47:0] RX_ACC_DIFF, // Accumulated bit difference
	output fctg_pkg::fctg_rxst_t RX_ST // Synchronised status
);
	import fctg_pkg::*;

	typedef enum logic [6:0] {
		ST_GAP = 7'h01, ST_SOF = 7'h02, ST_HDR = 7'h04, ST_PAY = 7'h08,
		ST_CRC = 7'h10, ST_EOF = 7'h20, ST_ALM = 7'h40
	} fctg_st_t;

	fctg_st_t st_r, st_nxt;
	fctg_word_t w, b0_r, b1_r;
	logic [1:0] bcnt_r, bcnt_nxt;
	logic in_rdy, pop;
	logic [9:0] cnt_r;
	logic [3:0] gap_r;
	logic [31:0] crc_r, prbs_r, prbs_out, prbs_nxt, pay, crc_upd, hdr_w;
	logic [5:0] fox_r;
	logic [15:0] seqcnt_r, pend_r;
	logic [31:0] sec_r;
	logic [3:0] tens_r;
	logic [23:0] blk_r, rate_div;
	logic sec_tick, burst_add, take, is_rate;
	logic [4:0] ord_r;
	fctg_rxst_t rx1_r, rx2_r;

	// Maximal-length feedback taps per order
	function automatic logic [31:0] tap_mask(input logic [4:0] o);
		case (o)
			5'd9: tap_mask = 32'h00000110;
			5'd10: tap_mask = 32'h00000240;
			5'd11: tap_mask = 32'h00000500;
			5'd12: tap_mask = 32'h00000829;
			5'd13: tap_mask = 32'h0000100D;
			5'd14: tap_mask = 32'h00002015;
			5'd15: tap_mask = 32'h00006000;
			5'd16: tap_mask = 32'h0000D008;
			5'd17: tap_mask = 32'h00012000;
			5'd18: tap_mask = 32'h00020400;
			5'd19: tap_mask = 32'h00040023;
			5'd20: tap_mask = 32'h00090000;
			5'd21: tap_mask = 32'h00140000;
			5'd22: tap_mask = 32'h00300000;
			5'd23: tap_mask = 32'h00420000;
			5'd24: tap_mask = 32'h00E10000;
			5'd25: tap_mask = 32'h01200000;
			5'd26: tap_mask = 32'h02000023;
			5'd27: tap_mask = 32'h04000013;
			5'd28: tap_mask = 32'h09000000;
			5'd29: tap_mask = 32'h14000000;
			5'd30: tap_mask = 32'h20000029;
			default: tap_mask = 32'h48000000;
		endcase
	endfunction

	// Thirty-two serial LFSR steps per word
	always_comb begin
		logic [31:0] s;
		logic fb;
		s = prbs_r;
		fb = 1'b0;
		prbs_out = 32'h00000000;
		for (int i = 31; i >= 0; i--) begin
			fb = ^(s & tap_mask(ord_r));
			s = {s[30:0], fb};
			prbs_out[i] = fb;
		end
		prbs_nxt = s;
	end

	// CRC update, MSB first, one word per step
	always_comb begin
		logic [31:0] c;
		c = crc_r;
		for (int i = 31; i >= 0; i--) begin
			c = (c[31] ^ w.data[i]) ? ({c[30:0], 1'b0} ^ CRC_POLY) : {c[30:0], 1'b0};
		end
		crc_upd = c;
	end

	// Header word by index; five fields come from the user
	always_comb begin
		case (cnt_r[2:0])
			3'd0: hdr_w = {HDR_RCTL, HDR.d_id};
			3'd1: hdr_w = {HDR_CSCTL, HDR.s_id};
			3'd2: hdr_w = {HDR_TYPE, HDR_FCTL};
			3'd3: hdr_w = {HDR.seq_id, HDR_DFCTL, seqcnt_r};
			3'd4: hdr_w = {HDR.ox_id, HDR.rx_id};
			default: hdr_w = HDR_PARM;
		endcase
	end

	// Payload pattern select
	always_comb begin
		logic [5:0] j;
		j = 6'h00;
		pay = 32'h00000000;
		for (int b = 0; b < 4; b++) begin
			j = (fox_r + 6'(b) >= 6'(FOX_LEN)) ? fox_r + 6'(b) - 6'(FOX_LEN) : fox_r + 6'(b);
			pay[31 - 8*b -: 8] = FOX_TXT[439 - 8*j -: 8];
		end
		case (PAT_SEL)
			PAT_FOX: pay = pay;
			PAT_55: pay = PAT_5555;
			PAT_PRBS: pay = prbs_out;
			PAT_USER: pay = USER_WORD;
			default: pay = 32'h00000000;
		endcase
	end

	// Error opportunity of the current word consumes one pending error
	always_comb begin
		take = 1'b0;
		if (pend_r != 16'h0000) begin
			case (ERR_SEL)
				ERR_BIT: take = (st_r == ST_PAY);
				ERR_SYM: take = (st_r == ST_PAY) && !TEN_GIG_RATE_MODE;
				ERR_CRC: take = (st_r == ST_CRC);
				ERR_RRDY: take = (st_r == ST_GAP);
				ERR_BLK: take = TEN_GIG_RATE_MODE;
				default: take = 1'b0;
			endcase
		end
	end

	// Word builder
	always_comb begin
		w = '{data: OS_IDLE, k: K_OS, inv: 1'b0, blk: 1'b0};
		case (st_r)
			ST_SOF: w.data = OS_SOF;
			ST_HDR: w = '{data: hdr_w, k: 4'h0, inv: 1'b0, blk: 1'b0};
			ST_PAY: begin
				w = '{data: pay, k: 4'h0, inv: 1'b0, blk: 1'b0};
				w.data[0] = pay[0] ^ (take && ERR_SEL == ERR_BIT);
				w.inv = take && ERR_SEL == ERR_SYM;
			end
			ST_CRC: begin
				w = '{data: ~crc_r, k: 4'h0, inv: 1'b0, blk: 1'b0};
				w.data[0] = ~crc_r[0] ^ (take && ERR_SEL == ERR_CRC);
			end
			ST_EOF: w.data = OS_EOF;
			ST_ALM: begin
				case (ALM_SEL)
					ALM_LR: w.data = OS_LR;
					ALM_LRR: w.data = OS_LRR;
					ALM_NOS: w.data = OS_NOS;
					default: w.data = OS_OLS;
				endcase
			end
			default: if (take && ERR_SEL == ERR_RRDY) w.data = OS_RRDY;
		endcase
		if (ERR_SEL == ERR_BLK) w.blk = take;
	end

	// Frame sequencer; alarms take over only at a word boundary in the gap
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ST_GAP: if (ALM_SEL != ALM_NONE) st_nxt = ST_ALM;
				else if (gap_r == 4'h0 && TX_EN) st_nxt = ST_SOF;
			ST_SOF: st_nxt = FRAMED ? ST_HDR : (PAY_WORDS != 10'h000 ? ST_PAY : ST_EOF);
			ST_HDR: if (cnt_r == HDR_WORDS - 10'h001)
					st_nxt = PAY_WORDS != 10'h000 ? ST_PAY : ST_CRC;
			ST_PAY: if (cnt_r == PAY_WORDS - 10'h001) st_nxt = FRAMED ? ST_CRC : ST_EOF;
			ST_CRC: st_nxt = ST_EOF;
			ST_EOF: st_nxt = ST_GAP;
			ST_ALM: if (ALM_SEL == ALM_NONE) st_nxt = ST_GAP;
			default: st_nxt = ST_GAP;
		endcase
	end

	// State, counters and running CRC advance only when the buffer has room
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			st_r <= ST_GAP;
			cnt_r <= 10'h000;
			gap_r <= GAP_WORDS;
			crc_r <= CRC_INIT;
			seqcnt_r <= 16'h0000;
		end else if (in_rdy) begin
			st_r <= st_nxt;
			cnt_r <= (st_nxt != st_r) ? 10'h000 : cnt_r + 10'h001;
			if (st_r == ST_GAP) gap_r <= (gap_r != 4'h0) ? gap_r - 4'h1 : 4'h0;
			else gap_r <= GAP_WORDS;
			if (st_r == ST_SOF) crc_r <= CRC_INIT;
			else if (st_r == ST_HDR || st_r == ST_PAY) crc_r <= crc_upd;
			if (st_r == ST_EOF) seqcnt_r <= seqcnt_r + 16'h0001;
		end
	end

	// Pattern state runs across frames; order latched at reset release or gap
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			prbs_r <= 32'hFFFFFFFF;
			fox_r <= 6'h00;
			ord_r <= 5'd31;
		end else begin
			if (st_r == ST_GAP) ord_r <= (PRBS_ORDER < 5'd9) ? 5'd9 : PRBS_ORDER;
			if (in_rdy && st_r == ST_PAY) begin
				prbs_r <= prbs_nxt;
				fox_r <= (fox_r + 6'h04 >= 6'(FOX_LEN)) ? fox_r + 6'h04 - 6'(FOX_LEN) : fox_r + 6'h04;
			end
		end
	end

	// One-second tick and ten-second divider; the count is a parameter for sim
	assign sec_tick = (sec_r == 32'(SEC_CYCLES - 1));
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sec_r <= 32'h00000000;
			tens_r <= 4'h0;
		end else begin
			sec_r <= sec_tick ? 32'h00000000 : sec_r + 32'h00000001;
			if (sec_tick) tens_r <= (tens_r == TEN_PERIODS - 4'h1) ? 4'h0 : tens_r + 4'h1;
		end
	end

	// Block count between bursts in rate modes
	always_comb begin
		case (INS_SEL)
			INS_R2: rate_div = 24'd100;
			INS_R3: rate_div = 24'd1000;
			INS_R4: rate_div = 24'd10000;
			INS_R5: rate_div = 24'd100000;
			INS_R6: rate_div = 24'd1000000;
			default: rate_div = 24'd10000000;
		endcase
		is_rate = INS_SEL >= INS_R2 && INS_SEL <= INS_R7;
		case (INS_SEL)
			INS_MAN: burst_add = INS_TRIG;
			INS_SEC: burst_add = sec_tick;
			INS_10SEC: burst_add = sec_tick && tens_r == 4'h0;
			default: burst_add = is_rate && in_rdy && blk_r == rate_div - 24'd1;
		endcase
	end

	// Pending error count; a new burst in the consuming cycle is not lost
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			pend_r <= 16'h0000;
			blk_r <= 24'h000000;
		end else begin
			if (in_rdy) blk_r <= (!is_rate || blk_r == rate_div - 24'd1) ? 24'h000000 : blk_r + 24'd1;
			if (INS_SEL == INS_OFF || ERR_SEL == ERR_NONE) pend_r <= 16'h0000;
			else if (burst_add)
				pend_r <= ({1'b0, pend_r} + {1'b0, BURST_LEN} - {16'h0000, take && in_rdy} > {1'b0, PEND_MAX})
					? PEND_MAX : pend_r + BURST_LEN - {15'h0000, take && in_rdy};
			else if (take && in_rdy) pend_r <= pend_r - 16'h0001;
		end
	end

	// Two-entry buffer so a stalled encoder never drops a word
	assign in_rdy = (bcnt_r != 2'd2);
	assign pop = (bcnt_r != 2'd0) && TX_READY;
	always_comb begin
		case ({in_rdy, pop})
			2'b10: bcnt_nxt = bcnt_r + 2'd1;
			2'b01: bcnt_nxt = bcnt_r - 2'd1;
			default: bcnt_nxt = bcnt_r;
		endcase
	end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			bcnt_r <= 2'd0;
			b0_r <= '0;
			b1_r <= '0;
			TX_VALID <= 1'b0;
		end else begin
			bcnt_r <= bcnt_nxt;
			TX_VALID <= (bcnt_nxt != 2'd0);
			if (bcnt_r == 2'd0 || (bcnt_r == 2'd1 && pop)) b0_r <= w;
			else if (bcnt_r == 2'd2 && pop) b0_r <= b1_r;
			if (bcnt_r == 2'd1 && !pop) b1_r <= w;
		end
	end
	assign TX_WORD = b0_r;

	// Coding select and frequency offset, registered straight out
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ENC_64B66B <= 1'b0;
			TX_DEV <= 32'sh00000000;
		end else begin
			ENC_64B66B <= TEN_GIG_RATE_MODE;
			TX_DEV <= FREQ_DEV;
		end
	end

	// Status pins pass three flops on their way to RX_ST
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rx1_r <= '0;
			rx2_r <= '0;
			RX_ST <= '0;
		end else begin
			rx1_r <= RX_ST_PIN;
			rx2_r <= rx1_r;
			RX_ST <= rx2_r;
		end
	end

	// Window difference; product widened first so large gains keep their top bits
	logic signed [32:0] d;
	logic signed [63:0] p;
	always_comb begin
		d = $signed({1'b0, RX_BIT_CNT}) - $signed({1'b0, NOM_BITS});
		p = 64'(d) * 64'($signed({1'b0, PPM_GAIN}));
	end

	// Rate deviation per window; ppm via a reciprocal gain avoids a divider
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			RX_DEV_BPS <= 32'sh00000000;
			RX_DEV_PPM <= 32'sh00000000;
			RX_ACC_DIFF <= 48'sh000000000000;
		end else begin
			if (RX_WIN_STB) begin
				RX_DEV_BPS <= 32'(d * $signed({1'b0, WIN_PER_SEC}));
				RX_DEV_PPM <= p[47:16];
			end
			if (MEAS_START) RX_ACC_DIFF <= 48'sh000000000000;
			else if (RX_WIN_STB) RX_ACC_DIFF <= RX_ACC_DIFF + 48'(d);
		end
	end
endmodule // fctg_top
`default_nettype wire
